/* hw/sfl_status_flags.sv */
// Status flags of the I2C controller: busy, arbitration, range match, direction
//
// Behaviour
// - Busy rises on START, falls on STOP
// - Hardware sets arbitration lost on lost arbitration
// - Arbitration lost cleared only by writing one
// - Range enabled: nonzero address equal range register matches
// - Range enabled: address inside primary-range span matches
// - Any first control write clears range flag
// - Slave direction holds received read/write bit
// - Addressed flag set on match before acknowledge
//
// Our own choices: the plain strobed port and the register offsets.
module sfl_status_flags
  import sfl_pkg::*;
(
  input  wire logic                        CLK_SYS_I,
  input  wire logic                        NRST_I,
  input  wire logic                        CE_I,
  input  wire logic [sfl_pkg::REG_AW-1:0]  REG_ADDR_I,
  input  wire logic [sfl_pkg::REG_DW-1:0]  REG_WDATA_I,
  input  wire logic                        REG_WR_I,
  input  wire logic                        REG_RD_I,
  output logic      [sfl_pkg::REG_DW-1:0]  REG_RDATA_O,
  input  wire logic                        SCL_I,
  input  wire logic                        SDA_I,
  input  wire logic                        ARB_LOST_I,
  output logic                             IRQ_O,
  output logic                             BUS_BUSY_O,
  output logic                             ADDRESSED_O,
  output logic                             SLAVE_DIR_O
);

  sfl_state_s st_reg;
  sfl_state_s st_next;

  logic start_evt;
  logic stop_evt;
  logic scl_rise;
  logic sda_smp;

  // Line condition detection
  sfl_cond_det u_cond_det
  (
    .clk_i      (CLK_SYS_I),
    .nrst_i     (NRST_I),
    .ce_i       (CE_I),
    .scl_i      (SCL_I),
    .sda_i      (SDA_I),
    .start_o    (start_evt),
    .stop_o     (stop_evt),
    .scl_rise_o (scl_rise),
    .sda_o      (sda_smp)
  );

  // Equality of two 7-bit addresses
  function automatic logic addr_eq(input logic [6:0] a, input logic [6:0] b);
    addr_eq = (a == b);
  endfunction : addr_eq

  // Address lies between two bounds given in either order
  function automatic logic addr_in_span(input logic [6:0] a, input logic [6:0] lo_hi, input logic [6:0] hi_lo);
    logic [6:0] lo;
    logic [6:0] hi;
    lo = (lo_hi < hi_lo) ? lo_hi : hi_lo;
    hi = (lo_hi < hi_lo) ? hi_lo : lo_hi;
    addr_in_span = (a >= lo) && (a <= hi);
  endfunction : addr_in_span

  // Status one layout, unused bits read zero
  function automatic logic [REG_DW-1:0] status_one(input sfl_state_s s);
    status_one              = RST_RDATA;
    status_one[S1_AAS_BIT]  = s.aas;
    status_one[S1_BUSY_BIT] = s.busy;
    status_one[S1_ARBITRATION_LOST_FLAG_BIT] = s.arbitration_lost_flag;
    status_one[S1_RAM_BIT]  = s.ram;
    status_one[S1_SRW_BIT]  = s.slave_direction_flag;
  endfunction : status_one

  // Decoded register strobes
  logic wr_pri;
  logic wr_c1;
  logic wr_s1;
  logic wr_c2;
  logic wr_rng;
  logic wr_sec;
  logic wr_mask;

  // Decoded read strobes
  logic rd_pri;
  logic rd_c1;
  logic rd_s1;
  logic rd_c2;
  logic rd_rng;
  logic rd_sec;
  logic rd_evt;
  logic rd_mask;

  // Address byte assembled on the last clock edge
  logic [7:0] addr_byte;
  logic [6:0] call_addr;
  logic       byte_done;
  logic       hit_pri;
  logic       hit_gc;
  logic       hit_sec;
  logic       hit_alert;
  logic       hit_rng;
  logic       hit_any;

  // Write decode
  always_comb
  begin
    wr_pri  = 1'b0;
    wr_c1   = 1'b0;
    wr_s1   = 1'b0;
    wr_c2   = 1'b0;
    wr_rng  = 1'b0;
    wr_sec  = 1'b0;
    wr_mask = 1'b0;
    if (REG_WR_I)
    begin
      if (REG_ADDR_I == OFS_PRIMARY_ADDR)
        wr_pri = 1'b1;
      else if (REG_ADDR_I == OFS_FIRST_CTRL)
        wr_c1 = 1'b1;
      else if (REG_ADDR_I == OFS_STATUS_ONE)
        wr_s1 = 1'b1;
      else if (REG_ADDR_I == OFS_SECOND_CTRL)
        wr_c2 = 1'b1;
      else if (REG_ADDR_I == OFS_RANGE_ADDR)
        wr_rng = 1'b1;
      else if (REG_ADDR_I == OFS_SECOND_ADDR)
        wr_sec = 1'b1;
      else if (REG_ADDR_I == OFS_EVT_MASK)
        wr_mask = 1'b1;
    end
  end

  // Read decode; only the event status read has a side effect
  always_comb
  begin
    rd_pri  = 1'b0;
    rd_c1   = 1'b0;
    rd_s1   = 1'b0;
    rd_c2   = 1'b0;
    rd_rng  = 1'b0;
    rd_sec  = 1'b0;
    rd_evt  = 1'b0;
    rd_mask = 1'b0;
    if (REG_RD_I)
    begin
      if (REG_ADDR_I == OFS_PRIMARY_ADDR)
        rd_pri = 1'b1;
      else if (REG_ADDR_I == OFS_FIRST_CTRL)
        rd_c1 = 1'b1;
      else if (REG_ADDR_I == OFS_STATUS_ONE)
        rd_s1 = 1'b1;
      else if (REG_ADDR_I == OFS_SECOND_CTRL)
        rd_c2 = 1'b1;
      else if (REG_ADDR_I == OFS_RANGE_ADDR)
        rd_rng = 1'b1;
      else if (REG_ADDR_I == OFS_SECOND_ADDR)
        rd_sec = 1'b1;
      else if (REG_ADDR_I == OFS_EVT_STATUS)
        rd_evt = 1'b1;
      else if (REG_ADDR_I == OFS_EVT_MASK)
        rd_mask = 1'b1;
    end
  end

  // Address comparison against every slave address source
  always_comb
  begin
    addr_byte = {st_reg.shift[6:0], sda_smp};
    call_addr = addr_byte[7:1];
    byte_done = scl_rise && (st_reg.rx_state == RX_ADDR) && (st_reg.bit_cnt == ADDR_LAST_BIT);
    hit_pri   = addr_eq(call_addr, st_reg.pri_addr);
    hit_gc    = st_reg.gc_en && addr_eq(call_addr, GEN_CALL_ADDR);
    hit_sec   = st_reg.sec_en && addr_eq(call_addr, st_reg.sec_addr);
    hit_alert = st_reg.alert_en && addr_eq(call_addr, ALERT_RESP_ADDR);
    hit_rng   = st_reg.rm_en &&
                ((!addr_eq(call_addr, GEN_CALL_ADDR) && addr_eq(call_addr, st_reg.rng_addr)) ||
                 addr_in_span(call_addr, st_reg.pri_addr, st_reg.rng_addr));
    hit_any   = st_reg.mod_en && (hit_pri || hit_gc || hit_sec || hit_alert || hit_rng);
  end

  // Next state
  always_comb
  begin
    st_next = st_reg;

    // Configuration registers
    if (wr_pri)
      st_next.pri_addr = REG_WDATA_I[ADDR_LSB +: 7];
    if (wr_rng)
      st_next.rng_addr = REG_WDATA_I[ADDR_LSB +: 7];
    if (wr_sec)
    begin
      st_next.sec_addr = REG_WDATA_I[ADDR_LSB +: 7];
      st_next.sec_en   = REG_WDATA_I[SEC_EN_BIT];
    end
    if (wr_c1)
    begin
      st_next.mod_en = REG_WDATA_I[C1_MOD_EN_BIT];
      st_next.int_en = REG_WDATA_I[C1_INT_EN_BIT];
    end
    if (wr_c2)
    begin
      st_next.gc_en    = REG_WDATA_I[C2_GC_EN_BIT];
      st_next.alert_en = REG_WDATA_I[C2_ALERT_EN_BIT];
      st_next.rm_en    = REG_WDATA_I[C2_RM_EN_BIT];
    end
    if (wr_mask)
      st_next.evt_mask = REG_WDATA_I[EVT_W-1:0];

    // Software clears first, hardware sets afterwards so sets win
    if (wr_c1)
    begin
      st_next.ram = 1'b0;
      st_next.aas = 1'b0;
    end
    if (wr_s1 && REG_WDATA_I[S1_ARBITRATION_LOST_FLAG_BIT])
      st_next.arbitration_lost_flag = 1'b0;
    if (rd_evt)
      st_next.evt = RST_EVT;

    // Bus busy follows conditions in any role
    if (start_evt)
      st_next.busy = 1'b1;
    else if (stop_evt)
      st_next.busy = 1'b0;

    // Arbitration loss reported by the master engine
    if (ARB_LOST_I)
    begin
      st_next.arbitration_lost_flag                = 1'b1;
      st_next.evt[EVT_ARBITRATION_LOST_FLAG_BIT]   = 1'b1;
    end

    // Address phase tracking
    case (st_reg.rx_state)
      // Waiting for a START
      RX_IDLE:
      begin
        st_next.bit_cnt = 4'h0;
      end
      // Shifting in the calling address
      RX_ADDR:
      begin
        if (scl_rise)
        begin
          st_next.shift   = addr_byte;
          st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
          if (byte_done)
            st_next.rx_state = RX_HOLD;
        end
      end
      // Data bytes ignored until START or STOP
      RX_HOLD:
      begin
        st_next.bit_cnt = 4'h0;
      end
      default:
      begin
        st_next.rx_state = RX_IDLE;
      end
    endcase

    // Conditions restart or end the address phase
    if (start_evt)
    begin
      st_next.rx_state = RX_ADDR;
      st_next.bit_cnt  = 4'h0;
      st_next.evt[EVT_START_BIT] = 1'b1;
    end
    else if (stop_evt)
    begin
      st_next.rx_state = RX_IDLE;
      st_next.evt[EVT_STOP_BIT] = 1'b1;
    end

    // Match result lands with the eighth bit, before acknowledge
    if (byte_done && !start_evt && !stop_evt)
    begin
      if (hit_any)
      begin
        st_next.aas = 1'b1;
        st_next.slave_direction_flag = addr_byte[0];
        st_next.evt[EVT_AAS_BIT] = 1'b1;
      end
      if (st_reg.mod_en && hit_rng)
        st_next.ram = 1'b1;
    end

    // Registered read data, one cycle after the strobe
    st_next.rdata = RST_RDATA;
    if (rd_pri)
      st_next.rdata = {st_reg.pri_addr, 1'b0};
    else if (rd_c1)
    begin
      st_next.rdata[C1_MOD_EN_BIT] = st_reg.mod_en;
      st_next.rdata[C1_INT_EN_BIT] = st_reg.int_en;
    end
    else if (rd_s1)
      st_next.rdata = status_one(st_reg);
    else if (rd_c2)
    begin
      st_next.rdata[C2_GC_EN_BIT]    = st_reg.gc_en;
      st_next.rdata[C2_ALERT_EN_BIT] = st_reg.alert_en;
      st_next.rdata[C2_RM_EN_BIT]    = st_reg.rm_en;
    end
    else if (rd_rng)
      st_next.rdata = {st_reg.rng_addr, 1'b0};
    else if (rd_sec)
      st_next.rdata = {st_reg.sec_addr, st_reg.sec_en};
    else if (rd_evt)
      st_next.rdata[EVT_W-1:0] = st_reg.evt;
    else if (rd_mask)
      st_next.rdata[EVT_W-1:0] = st_reg.evt_mask;
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge CLK_SYS_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      st_reg <= '{pri_addr: RST_ADDR, rng_addr: RST_ADDR, sec_addr: RST_ADDR,
                 evt: RST_EVT, evt_mask: RST_EVT, shift: 8'h00, bit_cnt: 4'h0,
                 rx_state: RX_IDLE, rdata: RST_RDATA, default: 1'b0};
    end
    else if (CE_I)
    begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign REG_RDATA_O = st_reg.rdata;
  assign IRQ_O       = |(st_reg.evt & st_reg.evt_mask);
  assign BUS_BUSY_O  = st_reg.busy;
  assign ADDRESSED_O = st_reg.aas;
  assign SLAVE_DIR_O = st_reg.slave_direction_flag;

endmodule : sfl_status_flags

/* hw/sfl_pkg.sv */
// Package with constants and types of the I2C status flag block
package sfl_pkg;

  // Register port widths
  localparam int REG_AW = 3;
  localparam int REG_DW = 8;

  // Register offsets
  localparam logic [REG_AW-1:0] OFS_PRIMARY_ADDR = 3'h0;
  localparam logic [REG_AW-1:0] OFS_FIRST_CTRL   = 3'h1;
  localparam logic [REG_AW-1:0] OFS_STATUS_ONE   = 3'h2;
  localparam logic [REG_AW-1:0] OFS_SECOND_CTRL  = 3'h3;
  localparam logic [REG_AW-1:0] OFS_RANGE_ADDR   = 3'h4;
  localparam logic [REG_AW-1:0] OFS_SECOND_ADDR  = 3'h5;
  localparam logic [REG_AW-1:0] OFS_EVT_STATUS   = 3'h6;
  localparam logic [REG_AW-1:0] OFS_EVT_MASK     = 3'h7;

  // Field positions: address registers hold the 7-bit address in [7:1]
  localparam int ADDR_LSB        = 1;
  localparam int SEC_EN_BIT      = 0;
  localparam int C1_MOD_EN_BIT   = 7;
  localparam int C1_INT_EN_BIT   = 6;
  localparam int C2_GC_EN_BIT    = 7;
  localparam int C2_ALERT_EN_BIT = 6;
  localparam int C2_RM_EN_BIT    = 3;
  localparam int S1_AAS_BIT      = 6;
  localparam int S1_BUSY_BIT     = 5;
  localparam int S1_ARBITRATION_LOST_FLAG_BIT     = 4;
  localparam int S1_RAM_BIT      = 3;
  localparam int S1_SRW_BIT      = 2;
  localparam int EVT_START_BIT   = 0;
  localparam int EVT_STOP_BIT    = 1;
  localparam int EVT_ARBITRATION_LOST_FLAG_BIT    = 2;
  localparam int EVT_AAS_BIT     = 3;
  localparam int EVT_W           = 4;

  // Reset values and fixed codes
  localparam logic [6:0]       RST_ADDR        = 7'h00;
  localparam logic [EVT_W-1:0] RST_EVT         = 4'h0;
  localparam logic [REG_DW-1:0] RST_RDATA      = 8'h00;
  localparam logic [6:0]       GEN_CALL_ADDR   = 7'h00;
  localparam logic [6:0]       ALERT_RESP_ADDR = 7'h0c;
  localparam logic [3:0]       ADDR_LAST_BIT   = 4'h7;

  // Address phase tracker
  typedef enum logic [1:0] {
    RX_IDLE,
    RX_ADDR,
    RX_HOLD
  } sfl_rx_e;

  // State of the bus condition detector
  typedef struct packed {
    logic scl_prev;
    logic sda_prev;
    logic start;
    logic stop;
    logic scl_rise;
    logic sda_smp;
  } sfl_det_s;

  // State of the status flag block
  typedef struct packed {
    logic [6:0]        pri_addr;
    logic [6:0]        rng_addr;
    logic [6:0]        sec_addr;
    logic              sec_en;
    logic              mod_en;
    logic              int_en;
    logic              gc_en;
    logic              alert_en;
    logic              rm_en;
    logic              aas;
    logic              busy;
    logic              arbitration_lost_flag;
    logic              ram;
    logic              slave_direction_flag;
    logic [EVT_W-1:0]  evt;
    logic [EVT_W-1:0]  evt_mask;
    logic [7:0]        shift;
    logic [3:0]        bit_cnt;
    sfl_rx_e           rx_state;
    logic [REG_DW-1:0] rdata;
  } sfl_state_s;

endpackage : sfl_pkg

/* hw/sfl_cond_det.sv */
// START, STOP and clock edge detector for the I2C lines
module sfl_cond_det
  import sfl_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic nrst_i,
  input  wire logic ce_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      start_o,
  output logic      stop_o,
  output logic      scl_rise_o,
  output logic      sda_o
);

  sfl_det_s det_reg;
  sfl_det_s det_next;

  // Conditions: data edge while clock stays high
  always_comb
  begin
    det_next          = det_reg;
    det_next.scl_prev = scl_i;
    det_next.sda_prev = sda_i;
    det_next.start    = det_reg.scl_prev & scl_i & det_reg.sda_prev & ~sda_i;
    det_next.stop     = det_reg.scl_prev & scl_i & ~det_reg.sda_prev & sda_i;
    det_next.scl_rise = ~det_reg.scl_prev & scl_i;
    det_next.sda_smp  = sda_i;
  end

  // Idle bus reads high after reset
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      det_reg <= '{scl_prev: 1'b1, sda_prev: 1'b1, sda_smp: 1'b1, default: 1'b0};
    end
    else if (ce_i)
    begin
      det_reg <= det_next;
    end
  end

  assign start_o    = det_reg.start;
  assign stop_o     = det_reg.stop;
  assign scl_rise_o = det_reg.scl_rise;
  assign sda_o      = det_reg.sda_smp;

endmodule : sfl_cond_det

/* verif/sfl_status_flags_assertions.sv */
// Checker for the status flag block ports
module sfl_status_flags_chk
  import sfl_pkg::*;
(
  input wire logic                       CLK_SYS_I,
  input wire logic                       NRST_I,
  input wire logic                       CE_I,
  input wire logic [sfl_pkg::REG_AW-1:0] REG_ADDR_I,
  input wire logic [sfl_pkg::REG_DW-1:0] REG_WDATA_I,
  input wire logic                       REG_WR_I,
  input wire logic                       REG_RD_I,
  input wire logic [sfl_pkg::REG_DW-1:0] REG_RDATA_O,
  input wire logic                       SCL_I,
  input wire logic                       SDA_I,
  input wire logic                       ARB_LOST_I,
  input wire logic                       IRQ_O,
  input wire logic                       BUS_BUSY_O,
  input wire logic                       ADDRESSED_O,
  input wire logic                       SLAVE_DIR_O
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (!NRST_I);

  // Steps of register traffic around the flags
  sequence rd_st;
    REG_RD_I && CE_I && REG_ADDR_I == OFS_STATUS_ONE;
  endsequence
  sequence arb_rd;
    ARB_LOST_I && CE_I ##1 !REG_WR_I ##1 rd_st;
  endsequence
  sequence arb_clr;
    REG_WR_I && CE_I && REG_ADDR_I == OFS_STATUS_ONE && REG_WDATA_I[S1_ARBITRATION_LOST_FLAG_BIT] && !ARB_LOST_I
    ##1 !REG_WR_I && !ARB_LOST_I ##1 rd_st ##0 !ARB_LOST_I;
  endsequence
  sequence c1_rd;
    REG_WR_I && CE_I && REG_ADDR_I == OFS_FIRST_CTRL && !BUS_BUSY_O
    ##1 !REG_WR_I && !BUS_BUSY_O ##1 rd_st ##0 !BUS_BUSY_O;
  endsequence
  sequence calm;
    !ARB_LOST_I && !BUS_BUSY_O && SCL_I && SDA_I && !REG_WR_I;
  endsequence
  sequence evt_rd;
    REG_RD_I && CE_I && REG_ADDR_I == OFS_EVT_STATUS && !ARB_LOST_I && !BUS_BUSY_O ##1 calm ##1 calm;
  endsequence

  a_busy_start: assert property (
    CE_I && SCL_I && $past(SCL_I) && $fell(SDA_I) |-> ##[1:3] BUS_BUSY_O)
    else $error("busy not set after start");
  a_busy_stop: assert property (
    CE_I && SCL_I && $past(SCL_I) && $rose(SDA_I) |-> ##[1:3] !BUS_BUSY_O)
    else $error("busy not cleared after stop");
  a_arbitration_lost_flag_set: assert property (arb_rd |=> REG_RDATA_O[S1_ARBITRATION_LOST_FLAG_BIT])
    else $error("arbitration flag not set");
  a_arbitration_lost_flag_clear: assert property (arb_clr |=> !REG_RDATA_O[S1_ARBITRATION_LOST_FLAG_BIT])
    else $error("arbitration flag not cleared");
  a_range_clear: assert property (
    c1_rd |=> !REG_RDATA_O[S1_RAM_BIT] && !REG_RDATA_O[S1_AAS_BIT])
    else $error("range flag kept after control write");
  a_irq_cleared: assert property (evt_rd |-> !IRQ_O)
    else $error("interrupt kept after status read");
  a_rdata_idle: assert property ($past(CE_I) && !$past(REG_RD_I) |-> REG_RDATA_O == RST_RDATA)
    else $error("read data outside read slot");
  a_dir_in_frame: assert property (
    $changed(SLAVE_DIR_O) || $rose(ADDRESSED_O) |-> BUS_BUSY_O)
    else $error("direction or address flag moved outside frame");
  a_reset_quiet: assert property (
    $rose(NRST_I) |-> !BUS_BUSY_O && !ADDRESSED_O && !SLAVE_DIR_O && !IRQ_O)
    else $error("outputs not quiet after reset");
endmodule : sfl_status_flags_chk

/* verif/sfl_i2c_peer.sv */
// Bus master model driving the I2C lines
module sfl_i2c_peer (
  input  wire logic clk_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Lines idle high through the pull-ups
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // One line phase, held four clocks
  task automatic step(input logic c, input logic d);
    @(posedge clk_i);
    scl_o <= c;
    sda_o <= d;
    repeat (3) @(posedge clk_i);
  endtask : step

  // Start, address byte MSB first, released ack slot, stop
  task automatic frame(input logic [7:0] b);
    step(1'b1, 1'b0);
    step(1'b0, 1'b0);
    for (int k = 7; k >= 0; k--)
    begin
      step(1'b0, b[k]);
      step(1'b1, b[k]);
      step(1'b0, b[k]);
    end
    step(1'b0, 1'b1);
    step(1'b1, 1'b1);
    step(1'b0, 1'b1);
    step(1'b0, 1'b0);
    step(1'b1, 1'b0);
    step(1'b1, 1'b1);
  endtask : frame
endmodule : sfl_i2c_peer

/* verif/tb.sv */
// Self-checking testbench of the status flag block
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("Error t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import sfl_pkg::*;

  logic              clk, nrst, ce, wr, rd, arb, irq, busy, aas_o, dir_o, scl, sda;
  logic [REG_AW-1:0] addr;
  logic [REG_DW-1:0] wdata, rdata, d, c1, c2;
  logic [6:0]        pri, rng, sec, a;
  logic [3:0]        evt, msk;
  logic              sen, rw, aas, ram, slave_direction_flag, arbitration_lost_flag, hit, rhit;
  int                n_fail, n_tests, lo, hi;
  logic [7:0]        wmask [8] = '{8'hfe, 8'hc0, 8'h00, 8'hc8, 8'hfe, 8'hff, 8'h00, 8'h0f};

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  sfl_status_flags i_dut (.CLK_SYS_I(clk), .NRST_I(nrst), .CE_I(ce), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata), .SCL_I(scl),
    .SDA_I(sda), .ARB_LOST_I(arb), .IRQ_O(irq), .BUS_BUSY_O(busy), .ADDRESSED_O(aas_o),
    .SLAVE_DIR_O(dir_o));
  sfl_i2c_peer i_peer (.clk_i(clk), .scl_o(scl), .sda_o(sda));

  // Register bus cycles
  task automatic wr_reg(input logic [2:0] r, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= r;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [2:0] r, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= r;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg

  // Expected status one contents
  function automatic logic [7:0] st_exp();
    return {1'b0, aas, 1'b0, arbitration_lost_flag, ram, slave_direction_flag, 2'b00};
  endfunction : st_exp

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : print_verdict

  // Watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    $display("Error t=%0t watchdog expired", $time);
    print_verdict();
  end

  // Test sequence
  initial
  begin
    {nrst, wr, rd, arb, addr, wdata} = '0;
    ce = 1'b1;
    {aas, ram, slave_direction_flag, arbitration_lost_flag, evt} = '0;
    void'($urandom(32'heb3a3719));
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    for (int r = 0; r < 8; r++)
    begin
      rd_reg(r[2:0], d);
      `CHK(d, 8'h00)
    end
    for (int r = 0; r < 8; r++)
    begin
      if (wmask[r] != 8'h00)
      begin
        wr_reg(r[2:0], 8'hff);
        rd_reg(r[2:0], d);
        `CHK(d, wmask[r])
      end
    end
    @(posedge clk);
    ce <= 1'b0;
    wr_reg(OFS_EVT_MASK, 8'h05);
    @(posedge clk);
    ce <= 1'b1;
    rd_reg(OFS_EVT_MASK, d);
    `CHK(d, 8'h0f)
    $display("Reset, access and enable tests done");
    for (int i = 0; i < 16; i++)
    begin
      pri = 7'($urandom_range(127, 1));
      rng = 7'($urandom_range(127, 1));
      sec = 7'($urandom);
      sen = 1'($urandom);
      c2 = 8'($urandom) & 8'hc8;
      c1 = ($urandom_range(3) == 0) ? 8'h40 : 8'hc0;
      msk = 4'($urandom) & {4{i[0]}};
      lo = (pri < rng) ? pri : rng;
      hi = (pri < rng) ? rng : pri;
      case ($urandom_range(5))
        0: a = pri;
        1: a = rng;
        2: a = 7'((lo + hi) / 2);
        3: a = GEN_CALL_ADDR;
        4: a = ALERT_RESP_ADDR;
        default: a = 7'($urandom);
      endcase
      rw = 1'($urandom);
      wr_reg(OFS_PRIMARY_ADDR, {pri, 1'b0});
      wr_reg(OFS_RANGE_ADDR, {rng, 1'b0});
      wr_reg(OFS_SECOND_ADDR, {sec, sen});
      wr_reg(OFS_SECOND_CTRL, c2);
      wr_reg(OFS_EVT_MASK, {4'h0, msk});
      wr_reg(OFS_FIRST_CTRL, c1);
      {aas, ram} = 2'b00;
      fork
        i_peer.frame({a, rw});
        begin
          repeat (12) @(posedge clk);
          `CHK(busy, 1'b1)
        end
      join
      rhit = c2[C2_RM_EN_BIT] && ((a != 7'h00 && a == rng) || (a >= lo && a <= hi));
      hit = a == pri || (c2[7] && a == 7'h00) || (sen && a == sec) || (c2[6] && a == 7'h0c) || rhit;
      hit = hit && c1[C1_MOD_EN_BIT];
      evt = evt | 4'h3 | (hit ? 4'h8 : 4'h0);
      if (hit)
      begin
        aas = 1'b1;
        ram = ram | rhit;
        slave_direction_flag = rw;
      end
      repeat (6) @(posedge clk);
      `CHK(busy, 1'b0)
      `CHK(aas_o, aas)
      `CHK(dir_o, slave_direction_flag)
      `CHK(irq, |(evt & msk))
      rd_reg(OFS_STATUS_ONE, d);
      `CHK(d, st_exp())
      rd_reg(OFS_EVT_STATUS, d);
      `CHK(d, {4'h0, evt})
      evt = 4'h0;
      repeat (2) @(posedge clk);
      `CHK(irq, 1'b0)
      wr_reg(OFS_FIRST_CTRL, 8'hc0);
      {aas, ram} = 2'b00;
      rd_reg(OFS_STATUS_ONE, d);
      `CHK(d, st_exp())
    end
    $display("Address frame tests done");
    @(posedge clk);
    arb <= 1'b1;
    @(posedge clk);
    arb <= 1'b0;
    arbitration_lost_flag = 1'b1;
    evt = 4'h4;
    rd_reg(OFS_STATUS_ONE, d);
    `CHK(d, st_exp())
    wr_reg(OFS_STATUS_ONE, 8'hef);
    rd_reg(OFS_STATUS_ONE, d);
    `CHK(d, st_exp())
    wr_reg(OFS_STATUS_ONE, 8'h10);
    arbitration_lost_flag = 1'b0;
    rd_reg(OFS_STATUS_ONE, d);
    `CHK(d, st_exp())
    @(posedge clk);
    arb <= 1'b1;
    wr <= 1'b1;
    addr <= OFS_STATUS_ONE;
    wdata <= 8'h10;
    @(posedge clk);
    {arb, wr} <= 2'b00;
    arbitration_lost_flag = 1'b1;
    rd_reg(OFS_STATUS_ONE, d);
    `CHK(d, st_exp())
    `CHK(irq, |(evt & msk))
    rd_reg(OFS_EVT_STATUS, d);
    `CHK(d, {4'h0, evt})
    repeat (2) @(posedge clk);
    $display("Arbitration tests done");
    @(posedge clk);
    arb <= 1'b1;
    @(posedge clk);
    arb <= 1'b0;
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    {aas, ram, slave_direction_flag, arbitration_lost_flag, evt} = '0;
    `CHK({busy, aas_o, dir_o, irq}, 4'h0)
    rd_reg(OFS_STATUS_ONE, d);
    `CHK(d, st_exp())
    rd_reg(OFS_EVT_MASK, d);
    `CHK(d, 8'h00)
    $display("Mid-run reset test done");
    print_verdict();
  end
endmodule : tb

bind sfl_status_flags sfl_status_flags_chk i_chk (.CLK_SYS_I(CLK_SYS_I), .NRST_I(NRST_I), .CE_I(CE_I),
  .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I), .REG_WR_I(REG_WR_I), .REG_RD_I(REG_RD_I),
  .REG_RDATA_O(REG_RDATA_O), .SCL_I(SCL_I), .SDA_I(SDA_I), .ARB_LOST_I(ARB_LOST_I), .IRQ_O(IRQ_O),
  .BUS_BUSY_O(BUS_BUSY_O), .ADDRESSED_O(ADDRESSED_O), .SLAVE_DIR_O(SLAVE_DIR_O));
